// ==== mis_map.svh ====
// register offsets, field positions, reset values and constants
// assumes inclusion by the sequencer and the testbench only
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH

// register port offsets
`define MIS_ADDR_MASK     3'h0
`define MIS_ADDR_STATUS   3'h1
`define MIS_ADDR_PENDING  3'h2
`define MIS_ADDR_MASK_HW  3'h3
`define MIS_ADDR_TBL_SEL  3'h4
`define MIS_ADDR_TBL_DATA 3'h5
`define MIS_ADDR_VEC_BASE 3'h6

// status fields
`define MIS_ST_ACTIVE     0
`define MIS_ST_EN_PEND    1
`define MIS_ST_INH_PEND   2
`define MIS_ST_BUSY       3
`define MIS_ST_LEVEL_LO   4
`define MIS_ST_LEVEL_HI   7

// reset values
`define MIS_RST_MASK      16'h0000
`define MIS_RST_VEC_BASE  16'h0000
`define MIS_RST_TBL_SEL   4'h0

// return-link location is offset field plus this
`define MIS_LINK_OFS      16'h0064
// first return-link location of level 00
`define MIS_LINK_BASE     16'h0064

`endif

// ==== mis_pkg.sv ====
// types shared by the macro interrupt sequencer
// assumes nothing of its surroundings
package mis_pkg;
	typedef enum logic [1:0] {
		mis_idle,
		mis_entry,
		mis_exit
	} mis_state_t;
endpackage

// ==== mis_word_store.sv ====
// small word store: one write port, one read port, registered read data
// assumes read and write share the one clock; contents have no reset
`timescale 1ns/1ps
module mis_word_store #(
	parameter int W  = 16,
	parameter int D  = 16,
	parameter int AW = 4
) (
	input  wire logic          ref_clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_q
);
	logic [W-1:0] mem [D];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule

// ==== mis_sequencer.sv ====
// sixteen-level macro interrupt sequencer beside a processor core
// assumes core gives one-cycle boundary strobes; irq lines are async pins
//
// Behaviour
// - test requests at each instruction boundary; hold fetch when taken
// - write next-instruction address into a fixed location, then vector
// - sixteen sources, one internal, fifteen external, each own vector
// - states 00 to 15 numbered as mask bits; bit n enters state n
// - programming bit 15 is msb; hardware view reverses the numbering
// - take request only if its mask bit set and system active
// - mask loaded by interregister instruction; enable sets active flag
// - on recognition store return address in that state's location
// - after saving, clear active flag and jump to the state handler
// - entering a state replaces the mask with that state's mask
// - sixteen priority levels, reordered at run time by mask reload
// - exit reads saved link, reactivates the system, jumps there
// - level 00 highest, internal; level 15 lowest
// - one instruction runs after enable before any interrupt taken
// - inhibit takes effect at the second following instruction fetch
// - exit link location is offset field plus 100
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "mis_map.svh"
module mis_sequencer #(
	parameter int LEVELS = 16,
	parameter int AW     = 16
) (
	input  wire logic          ref_clk,
	input  wire logic          arst_n,
	input  wire logic [15:0]   irq_req,
	input  wire logic          instr_done,
	input  wire logic [AW-1:0] next_pc,
	input  wire logic          enable_interrupts_instr,
	input  wire logic          inhibit_interrupts_instr,
	input  wire logic          return_from_interrupt_instr,
	input  wire logic [7:0]    exit_delta,
	input  wire logic          mask_load,
	input  wire logic [15:0]   mask_load_data,
	input  wire logic [2:0]    reg_addr,
	input  wire logic [15:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [15:0]   reg_rdata,
	output logic               int_take,
	output logic      [AW-1:0] int_vector,
	output logic      [3:0]    int_level,
	output logic               fetch_hold,
	output logic               ret_jump,
	output logic      [AW-1:0] ret_addr,
	output logic      [15:0]   macro_level_mask,
	output logic               int_active
);
	// lowest set bit wins: level 00 is highest priority
	function automatic logic [4:0] pick_first(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// programming bit n is hardware bit 15-n
	function automatic logic [15:0] to_hw_view(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[15-i] = v[i];
		end
		return r;
	endfunction

	logic [15:0] sync1_q, sync2_q;
	mis_pkg::mis_state_t st_q, st_d;
	logic [15:0]   mask_q, mask_d;
	logic          active_q, active_d;
	logic          en_pend_q, en_pend_d;
	logic          inh_pend_q, inh_pend_d;
	logic          hold_q, hold_d;
	logic          take_q, take_d;
	logic          jump_q, jump_d;
	logic [3:0]    level_q, level_d;
	logic [AW-1:0] vec_q, vec_d;
	logic [AW-1:0] ret_q, ret_d;
	logic [AW-1:0] vec_base_q, vec_base_d;
	logic [3:0]    tbl_sel_q, tbl_sel_d;
	logic [15:0]   rdata_q, rdata_d;
	logic [15:0]   elig_q, elig_d;

	logic          eff_active;
	logic [15:0]   eligible;
	logic [4:0]    pick;
	logic          boundary;
	logic          accept;
	logic          do_exit;
	logic [15:0]   link_loc;
	logic [15:0]   link_rel;
	logic [3:0]    link_idx;
	logic [AW-1:0] link_rdata;
	logic [15:0]   smask_rdata;
	logic          tbl_we;

	// request pins are asynchronous: two-stage synchroniser
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
		end else begin
			sync1_q <= irq_req;
			sync2_q <= sync1_q;
		end
	end

	// return links, one per level
	mis_word_store #(.W(AW), .D(LEVELS), .AW(4)) u_links (
		.ref_clk (ref_clk),
		.we      (accept),
		.waddr   (pick[3:0]),
		.wdata   (next_pc),
		.raddr   (link_idx),
		.rdata_q (link_rdata)
	);

	// per-state masks, written by software
	mis_word_store #(.W(16), .D(LEVELS), .AW(4)) u_state_masks (
		.ref_clk (ref_clk),
		.we      (tbl_we),
		.waddr   (tbl_sel_q),
		.wdata   (reg_wdata),
		.raddr   (pick[3:0]),
		.rdata_q (smask_rdata)
	);

	always_comb begin
		// delayed enable and inhibit settle at the next boundary
		if (en_pend_q) begin
			eff_active = 1'b1;
		end else if (inh_pend_q) begin
			eff_active = 1'b0;
		end else begin
			eff_active = active_q;
		end
		eligible = sync2_q & mask_q;
		pick     = pick_first(eligible);
		boundary = (st_q == mis_pkg::mis_idle) && instr_done;
		do_exit  = boundary && return_from_interrupt_instr;
		accept   = boundary && !return_from_interrupt_instr
			&& eff_active && pick[4];
		link_loc = {8'h00, exit_delta} + `MIS_LINK_OFS;
		link_rel = link_loc - `MIS_LINK_BASE;
		link_idx = link_rel[3:0];
		tbl_we   = reg_wr && (reg_addr == `MIS_ADDR_TBL_DATA);
	end

	always_comb begin
		st_d       = st_q;
		mask_d     = mask_q;
		active_d   = active_q;
		en_pend_d  = en_pend_q;
		inh_pend_d = inh_pend_q;
		hold_d     = hold_q;
		take_d     = 1'b0;
		jump_d     = 1'b0;
		level_d    = level_q;
		vec_d      = vec_q;
		ret_d      = ret_q;
		elig_d     = elig_q;
		vec_base_d = vec_base_q;
		tbl_sel_d  = tbl_sel_q;

		// software writes, lowest precedence for the mask
		if (reg_wr) begin
			unique case (reg_addr)
				`MIS_ADDR_MASK:     mask_d     = reg_wdata;
				`MIS_ADDR_TBL_SEL:  tbl_sel_d  = reg_wdata[3:0];
				`MIS_ADDR_VEC_BASE: vec_base_d = AW'(reg_wdata);
				default: ;
			endcase
		end
		if (mask_load) begin
			mask_d = mask_load_data;
		end

		unique case (st_q)
			mis_pkg::mis_idle: begin
				if (boundary) begin
					active_d   = eff_active;
					en_pend_d  = enable_interrupts_instr;
					inh_pend_d = inhibit_interrupts_instr;
					if (do_exit) begin
						st_d   = mis_pkg::mis_exit;
						hold_d = 1'b1;
					end else if (accept) begin
						// link written by u_links this edge
						st_d       = mis_pkg::mis_entry;
						hold_d     = 1'b1;
						active_d   = 1'b0;
						en_pend_d  = 1'b0;
						inh_pend_d = 1'b0;
						level_d    = pick[3:0];
						elig_d     = eligible;
					end
				end
			end
			mis_pkg::mis_entry: begin
				mask_d = smask_rdata;
				vec_d  = vec_base_q + AW'(level_q);
				take_d = 1'b1;
				hold_d = 1'b0;
				st_d   = mis_pkg::mis_idle;
			end
			mis_pkg::mis_exit: begin
				ret_d    = link_rdata;
				jump_d   = 1'b1;
				active_d = 1'b1;
				hold_d   = 1'b0;
				st_d     = mis_pkg::mis_idle;
			end
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`MIS_ADDR_MASK:     rdata_d = mask_q;
				`MIS_ADDR_STATUS: begin
					rdata_d[`MIS_ST_ACTIVE]   = active_q;
					rdata_d[`MIS_ST_EN_PEND]  = en_pend_q;
					rdata_d[`MIS_ST_INH_PEND] = inh_pend_q;
					rdata_d[`MIS_ST_BUSY] = st_q != mis_pkg::mis_idle;
					rdata_d[`MIS_ST_LEVEL_HI:`MIS_ST_LEVEL_LO] = level_q;
				end
				`MIS_ADDR_PENDING:  rdata_d = sync2_q;
				`MIS_ADDR_MASK_HW:  rdata_d = to_hw_view(mask_q);
				`MIS_ADDR_TBL_SEL:  rdata_d = {12'h000, tbl_sel_q};
				`MIS_ADDR_VEC_BASE: rdata_d = 16'(vec_base_q);
				default:            rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q       <= mis_pkg::mis_idle;
			mask_q     <= `MIS_RST_MASK;
			active_q   <= 1'b0;
			en_pend_q  <= 1'b0;
			inh_pend_q <= 1'b0;
			hold_q     <= 1'b0;
			take_q     <= 1'b0;
			jump_q     <= 1'b0;
			level_q    <= 4'h0;
			vec_q      <= '0;
			ret_q      <= '0;
			elig_q     <= 16'h0000;
			vec_base_q <= AW'(`MIS_RST_VEC_BASE);
			tbl_sel_q  <= `MIS_RST_TBL_SEL;
			rdata_q    <= 16'h0000;
		end else begin
			st_q       <= st_d;
			mask_q     <= mask_d;
			active_q   <= active_d;
			en_pend_q  <= en_pend_d;
			inh_pend_q <= inh_pend_d;
			hold_q     <= hold_d;
			take_q     <= take_d;
			jump_q     <= jump_d;
			level_q    <= level_d;
			vec_q      <= vec_d;
			ret_q      <= ret_d;
			elig_q     <= elig_d;
			vec_base_q <= vec_base_d;
			tbl_sel_q  <= tbl_sel_d;
			rdata_q    <= rdata_d;
		end
	end

	assign reg_rdata        = rdata_q;
	assign int_take         = take_q;
	assign int_vector       = vec_q;
	assign int_level        = level_q;
	assign fetch_hold       = hold_q;
	assign ret_jump         = jump_q;
	assign ret_addr         = ret_q;
	assign macro_level_mask = mask_q;
	assign int_active       = active_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	a_mask_gates_take: assert property (
		(boundary && !do_exit && (eligible == 16'h0000))
		|=> (st_q == mis_pkg::mis_idle) ##1 !take_q)
		else $error("interrupt taken with no enabled request");

	a_accept_holds_fetch: assert property (
		accept |=> hold_q && !take_q ##1 take_q && !hold_q)
		else $error("fetch hold or vector timing wrong on entry");

	a_entry_deactivates: assert property (
		accept |=> !active_q ##1 (!active_q && take_q))
		else $error("active flag not cleared on entry");

	a_vector_per_level: assert property (
		take_q |-> (int_vector == vec_base_q + AW'(level_q)))
		else $error("vector does not match level");

	a_highest_level_wins: assert property (
		take_q |-> (elig_q[level_q]
			&& ((elig_q & ((16'h0001 << level_q) - 16'h0001)) == 16'h0000)))
		else $error("serviced level is not the highest pending");

	a_state_mask_loads: assert property (
		(st_q == mis_pkg::mis_entry) |=> (mask_q == $past(smask_rdata)))
		else $error("state mask not placed in mask register");

	a_exit_returns: assert property (
		do_exit |=> ##1 (ret_jump && int_active && ret_addr == $past(link_rdata)))
		else $error("exit did not jump to saved link and reactivate");

	a_enable_delayed: assert property (
		(boundary && enable_interrupts_instr && !eff_active && !do_exit)
		|=> !active_q && !take_q ##1 !take_q)
		else $error("interrupt possible right after enable");

	a_inhibit_delayed: assert property (
		(boundary && inhibit_interrupts_instr && eff_active && !accept
			&& !do_exit) |=> active_q)
		else $error("inhibit took effect too early");

	a_link_saved: assert property (
		accept |=> ##1 (u_links.mem[level_q] == $past(next_pc, 2)))
		else $error("return link not stored for level");
endmodule

// ==== mis_irq_src.sv ====
// peripheral request lines: each level held until its entry is taken
// assumes raise pulses from the bench on the sequencer's clock
`timescale 1ns/1ps
module mis_irq_src (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] raise,
	input  wire logic        slow,
	input  wire logic        int_take,
	input  wire logic [3:0]  int_level,
	output logic      [15:0] irq_req
);
	logic [15:0] req_q;
	logic [15:0] req_d;
	logic [1:0]  lag_q;
	logic [1:0]  lag_d;
	logic [3:0]  lvl_q;
	logic [3:0]  lvl_d;
	always_comb begin
		req_d = req_q | raise;
		lag_d = (lag_q != 2'h0) ? lag_q - 2'h1 : 2'h0;
		lvl_d = lvl_q;
		if (lag_q == 2'h1) begin
			req_d[lvl_q] = 1'b0;
		end
		// slow peripheral drops its line three cycles late
		if (int_take && slow) begin
			lag_d = 2'h3;
			lvl_d = int_level;
		end else if (int_take) begin
			req_d[int_level] = 1'b0;
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= 16'h0000;
			lag_q <= 2'h0;
			lvl_q <= 4'h0;
		end else begin
			req_q <= req_d;
			lag_q <= lag_d;
			lvl_q <= lvl_d;
		end
	end
	// bit n is level n, level 00 the internal source
	assign irq_req = req_q;
endmodule

// ==== tb_top.sv ====
// testbench of the macro interrupt sequencer
// assumes mis_irq_src as request source; all waits bounded
`timescale 1ns/1ps
`include "mis_map.svh"
module tb_top;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [15:0] raise = 16'h0000;
	logic        slow = 1'b0;
	logic [15:0] irq_req;
	logic        instr_done = 1'b0;
	logic [15:0] next_pc = 16'h0000;
	logic        enable_interrupts_instr = 1'b0;
	logic        inhibit_interrupts_instr = 1'b0;
	logic        return_from_interrupt_instr = 1'b0;
	logic [7:0]  exit_delta = 8'h00;
	logic        mask_load = 1'b0;
	logic [15:0] mask_load_data = 16'h0000;
	logic [2:0]  reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        int_take;
	logic [15:0] int_vector;
	logic [3:0]  int_level;
	logic        fetch_hold;
	logic        ret_jump;
	logic [15:0] ret_addr;
	logic [15:0] macro_level_mask;
	logic        int_active;
	int          mismatches = 0;
	int          check_count = 0;

	always #50 ref_clk = ~ref_clk;

	mis_sequencer mis_sequencer_inst (.ref_clk, .arst_n, .irq_req,
		.instr_done, .next_pc, .enable_interrupts_instr,
		.inhibit_interrupts_instr, .return_from_interrupt_instr,
		.exit_delta, .mask_load, .mask_load_data, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .int_take, .int_vector, .int_level,
		.fetch_hold, .ret_jump, .ret_addr, .macro_level_mask, .int_active);
	mis_irq_src mis_irq_src_inst (.ref_clk, .arst_n, .raise, .slow,
		.int_take, .int_level, .irq_req);

	task automatic end_sim;
		if (mismatches == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] smask(input logic [3:0] n);
		return (16'h0001 << n) - 16'h0001;
	endfunction

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, e);
	endtask

	task automatic mload(input logic [15:0] d);
		@(posedge ref_clk);
		mask_load <= 1'b1;
		mask_load_data <= d;
		@(posedge ref_clk);
		mask_load <= 1'b0;
	endtask

	task automatic req(input logic [15:0] m);
		@(posedge ref_clk);
		raise <= m;
		@(posedge ref_clk);
		raise <= 16'h0000;
		idle(4);
	endtask

	// k = {exit, inhibit, enable}; pc is next_pc, or expected link on exit
	task automatic bnd(input logic [2:0] k, input logic [15:0] pc,
		input logic [3:0] lv, input logic tk);
		@(posedge ref_clk);
		instr_done <= 1'b1;
		return_from_interrupt_instr <= k[2];
		inhibit_interrupts_instr <= k[1];
		enable_interrupts_instr <= k[0];
		next_pc <= k[2] ? ~pc : pc;
		exit_delta <= {4'h0, lv};
		@(posedge ref_clk);
		instr_done <= 1'b0;
		@(negedge ref_clk);
		chk(fetch_hold, tk | k[2]);
		@(negedge ref_clk);
		chk(int_take, tk);
		chk(ret_jump, k[2]);
		if (tk) begin
			chk(int_level, lv);
			chk(int_vector, 16'h0200 + lv);
			chk(macro_level_mask, smask(lv));
			chk(int_active, 1'b0);
		end
		if (k[2]) begin
			chk(ret_addr, pc);
			chk(int_active, 1'b1);
		end
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_sim();
	end

	initial begin
		idle(6);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		chk(int_active, 1'b0);
		rd(`MIS_ADDR_STATUS, 16'h0000);
		wr(`MIS_ADDR_MASK, 16'h0013);
		rd(`MIS_ADDR_MASK, 16'h0013);
		rd(`MIS_ADDR_MASK_HW, 16'hC800);
		rd(3'h7, 16'h0000);
		wr(`MIS_ADDR_STATUS, 16'hFFFF);
		rd(`MIS_ADDR_STATUS, 16'h0000);
		wr(`MIS_ADDR_VEC_BASE, 16'h0200);
		rd(`MIS_ADDR_VEC_BASE, 16'h0200);
		for (int n = 0; n < 16; n++) begin
			wr(`MIS_ADDR_TBL_SEL, 16'(n));
			wr(`MIS_ADDR_TBL_DATA, smask(4'(n)));
		end
		mload(16'hFFFF);
		req(16'h0008);
		rd(`MIS_ADDR_PENDING, 16'h0008);
		bnd(3'h0, 16'h1111, 4'h0, 1'b0);
		bnd(3'h1, 16'h1112, 4'h0, 1'b0);
		rd(`MIS_ADDR_STATUS, 16'h0002);
		bnd(3'h0, 16'h1234, 4'h3, 1'b1);
		bnd(3'h4, 16'h1234, 4'h3, 1'b0);
		mload(16'hFFEF);
		req(16'h0010);
		bnd(3'h0, 16'h2000, 4'h0, 1'b0);
		mload(16'hFFFF);
		bnd(3'h2, 16'h2001, 4'h4, 1'b1);
		bnd(3'h4, 16'h2001, 4'h4, 1'b0);
		mload(16'hFFFF);
		bnd(3'h2, 16'h3000, 4'h0, 1'b0);
		rd(`MIS_ADDR_STATUS, 16'h0045);
		req(16'h0040);
		bnd(3'h0, 16'h3001, 4'h0, 1'b0);
		bnd(3'h1, 16'h3002, 4'h0, 1'b0);
		bnd(3'h0, 16'h3003, 4'h6, 1'b1);
		bnd(3'h4, 16'h3003, 4'h6, 1'b0);
		@(posedge ref_clk);
		slow <= 1'b1;
		req(16'hFFFF);
		for (int n = 0; n < 16; n++) begin
			mload(16'hFFFF);
			bnd(3'h0, 16'h4000 + 16'(n), 4'(n), 1'b1);
			bnd(3'h4, 16'h4000 + 16'(n), 4'(n), 1'b0);
			idle(6);
		end
		end_sim();
	end
endmodule
